// *** verilog/lpcal_seq.sv ***
// Purpose: calibration trigger select and low-power sleep/settle sequencer
// Assumes: register port writes and reads are single-cycle strobes
// Notes:   counters are long; shorten the period parameters for simulation
`timescale 1ns/1ns
`default_nettype none
module lpcal_seq
  import lpcal_pkg::*;
#(
  parameter logic [CNT_W-1:0] SLEEP_CYCLES [8] = SLEEP_PERIODS,
  parameter logic [CNT_W-1:0] SETTLE_CYCLES [4] = SETTLE_PERIODS
) (
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  input  wire logic              reg_wr_en_in,
  input  wire logic              reg_rd_en_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              cal_trigger_pin_in,
  input  wire logic              trigger_source_select_in,
  input  wire logic              background_cal_enable_in,
  input  wire logic [7:0]        fuse_gain_trim_in,
  input  wire logic              cal_done_in,
  output logic      [7:0]        reg_rdata_out,
  output logic                   cal_trigger_out,
  output logic                   core_sleep_out,
  output logic                   cal_start_out,
  output logic      [7:0]        gain_trim_out
);

  // elaboration checks: counter width, and no zero interval that would wrap on load
  if (CNT_W < 41) begin : g_cnt_width
    $error("interval counter too narrow");
  end
  for (genvar i = 0; i < 8; i++) begin : g_sleep_chk
    if (SLEEP_CYCLES[i] == CNT_ZERO) begin : g_sleep_zero
      $error("sleep interval of zero cannot be loaded");
    end
  end
  for (genvar j = 0; j < 4; j++) begin : g_settle_chk
    if (SETTLE_CYCLES[j] == CNT_ZERO) begin : g_settle_zero
      $error("settle interval of zero cannot be loaded");
    end
  end

  lpcal_all_t st_reg;
  lpcal_all_t st_next;
  logic       lp_active;
  logic       wake_now;
  logic [2:0] sleep_code;
  logic [1:0] settle_code;

  //////////////////////////////////////////////////////////////////////////
  // decode of control fields
  assign sleep_code  = st_reg.regs.lp_ctrl[SLEEP_LSB +: 3];
  assign settle_code = st_reg.regs.lp_ctrl[SETTLE_LSB +: 2];
  assign lp_active   = st_reg.regs.lp_ctrl[LOWPWR_ON_BIT] & background_cal_enable_in;
  // wake on low trigger in triggered mode, else on count expiry
  assign wake_now = st_reg.regs.lp_ctrl[TRIG_SLEEP_BIT] ? ~st_reg.trig
                                                        : (st_reg.cnt == CNT_ZERO);

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.cal_start = 1'b0;
    // register writes
    if (reg_wr_en_in) begin
      unique case (reg_addr_in)
        ADDR_SOFT_TRIG: st_next.regs.soft_trig = reg_wdata_in;
        ADDR_LP_CTRL:   st_next.regs.lp_ctrl = reg_wdata_in;
        ADDR_GAIN_TRIM: st_next.regs.gain_trim = reg_wdata_in;
        default:        st_next.regs = st_reg.regs;
      endcase
    end
    // register reads, unmapped reads as zero
    if (reg_rd_en_in) begin
      unique case (reg_addr_in)
        ADDR_SOFT_TRIG: st_next.rdata = st_reg.regs.soft_trig;
        ADDR_LP_CTRL:   st_next.rdata = st_reg.regs.lp_ctrl;
        ADDR_GAIN_TRIM: st_next.rdata = st_reg.regs.gain_trim;
        default:        st_next.rdata = 8'h00;
      endcase
    end
    // trigger source select
    st_next.trig = trigger_source_select_in ? cal_trigger_pin_in
                                            : st_reg.regs.soft_trig[SOFT_TRIG_BIT];
    // sequencer
    if (st_reg.cnt != CNT_ZERO) begin
      st_next.cnt = st_reg.cnt - CNT_ONE;
    end
    if (!lp_active) begin
      st_next.state = LPCAL_IDLE;
      st_next.sleep = 1'b0;
      st_next.cnt = CNT_ZERO;
    end else begin
      unique case (st_reg.state)
        LPCAL_IDLE, LPCAL_CAL: begin
          if (st_reg.state == LPCAL_IDLE || cal_done_in) begin
            st_next.state = LPCAL_SLEEP;
            st_next.sleep = 1'b1;
            st_next.cnt = SLEEP_CYCLES[sleep_code] - CNT_ONE;
          end
        end
        LPCAL_SLEEP: begin
          if (wake_now) begin
            st_next.state = LPCAL_SETTLE;
            st_next.sleep = 1'b0;
            st_next.cnt = SETTLE_CYCLES[settle_code] - CNT_ONE;
          end
        end
        LPCAL_SETTLE: begin
          if (st_reg.cnt == CNT_ZERO) begin
            st_next.state = LPCAL_CAL;
            st_next.cal_start = 1'b1;
          end
        end
      endcase
    end
    // synchronous reset, gain trim from fuse
    if (!rst_n_in) begin
      st_next = '0;
      st_next.state = LPCAL_IDLE;
      st_next.regs.soft_trig = RST_SOFT_TRIG;
      st_next.regs.lp_ctrl = RST_LP_CTRL;
      st_next.regs.gain_trim = fuse_gain_trim_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock_in) begin
    st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign reg_rdata_out   = st_reg.rdata;
  assign cal_trigger_out = st_reg.trig;
  assign core_sleep_out  = st_reg.sleep;
  assign cal_start_out   = st_reg.cal_start;
  assign gain_trim_out   = st_reg.regs.gain_trim;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_trig_from_pin: assert property (
    $past(trigger_source_select_in) && $past(rst_n_in)
      |-> cal_trigger_out == $past(cal_trigger_pin_in))
    else $error("trigger not taken from pin");
  a_trig_from_soft: assert property (
    !$past(trigger_source_select_in) && $past(rst_n_in)
      |-> cal_trigger_out == $past(st_reg.regs.soft_trig[SOFT_TRIG_BIT]))
    else $error("trigger not taken from register bit");
  a_gain_fuse_load: assert property (
    $rose(rst_n_in) |-> gain_trim_out == $past(fuse_gain_trim_in))
    else $error("gain trim not loaded from fuse");
  a_idle_when_off: assert property (
    !$past(lp_active) |-> !core_sleep_out && st_reg.state == LPCAL_IDLE)
    else $error("sequencer active while disabled");
  a_trig_wake: assert property (
    lp_active && st_reg.state == LPCAL_SLEEP && st_reg.regs.lp_ctrl[TRIG_SLEEP_BIT]
      && !cal_trigger_out |=> !core_sleep_out || !$past(lp_active))
    else $error("core not woken by low trigger");
  a_trig_hold_sleep: assert property (
    lp_active && st_reg.state == LPCAL_SLEEP && st_reg.regs.lp_ctrl[TRIG_SLEEP_BIT]
      && cal_trigger_out && $stable(lp_active) |=> core_sleep_out || !lp_active)
    else $error("core woke while trigger high");
  a_settle_then_cal: assert property (
    lp_active && st_reg.state == LPCAL_SETTLE && st_reg.cnt == CNT_ZERO
      |=> cal_start_out || !$past(lp_active, 1))
    else $error("calibration not started after settle");
  a_start_one_cycle: assert property (
    cal_start_out |=> !cal_start_out)
    else $error("calibration start longer than one cycle");
  a_auto_sleep_len: assert property (
    lp_active && !st_reg.regs.lp_ctrl[TRIG_SLEEP_BIT] && st_reg.state == LPCAL_SLEEP
      && st_reg.cnt != CNT_ZERO |=> core_sleep_out || !$past(lp_active))
    else $error("autonomous sleep ended early");
  a_sleep_load: assert property (
    st_reg.state != LPCAL_SLEEP && st_next.state == LPCAL_SLEEP && rst_n_in
      |=> st_reg.cnt == SLEEP_CYCLES[$past(sleep_code)] - CNT_ONE)
    else $error("sleep interval loaded wrong");
  // loads, counting, background-enable gating and the register port
  a_settle_load: assert property (
    st_reg.state != LPCAL_SETTLE && st_next.state == LPCAL_SETTLE && rst_n_in
      |=> st_reg.cnt == SETTLE_CYCLES[$past(settle_code)] - CNT_ONE)
    else $error("settle interval loaded wrong");
  a_auto_wake: assert property (
    lp_active && !st_reg.regs.lp_ctrl[TRIG_SLEEP_BIT] && st_reg.state == LPCAL_SLEEP
      && st_reg.cnt == CNT_ZERO |=> !core_sleep_out)
    else $error("autonomous sleep did not end on time");
  a_count_down: assert property (
    lp_active && st_reg.state == LPCAL_SETTLE && st_reg.cnt != CNT_ZERO
      |=> st_reg.cnt == $past(st_reg.cnt) - CNT_ONE)
    else $error("settle counter did not step by one");
  a_bg_off_awake: assert property (
    !background_cal_enable_in |=> !core_sleep_out)
    else $error("core asleep without background calibration");
  a_gain_write: assert property (
    reg_wr_en_in && reg_addr_in == ADDR_GAIN_TRIM
      |=> gain_trim_out == $past(reg_wdata_in))
    else $error("gain trim write not applied to cores");
  a_soft_read: assert property (
    reg_rd_en_in && reg_addr_in == ADDR_SOFT_TRIG
      |=> reg_rdata_out == $past(st_reg.regs.soft_trig))
    else $error("trigger register read back wrong");

endmodule
`default_nettype wire

// *** verilog/lpcal_pkg.sv ***
// Purpose: constants and types for the low-power calibration sequencer
// Assumes: one clock, the sample clock, drives the block
// Notes:   interval figures are in sample-clock periods
`default_nettype none
package lpcal_pkg;
  localparam int CNT_W = 41;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_SOFT_TRIG = 15'h006c;
  localparam logic [ADDR_W-1:0] ADDR_LP_CTRL = 15'h006e;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_TRIM = 15'h007a;
  // reset values
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] RST_LP_CTRL = 8'h88;
  // field positions
  localparam int SOFT_TRIG_BIT = 0;
  localparam int LOWPWR_ON_BIT = 0;
  localparam int TRIG_SLEEP_BIT = 1;
  localparam int SETTLE_LSB = 3;
  localparam int SLEEP_LSB = 5;
  // intervals in sample-clock periods, the time unit of this block
  localparam logic [CNT_W-1:0] SLEEP_PERIODS [8] = '{
    41'h000_0000_0480, 41'h000_0040_0080, 41'h000_0200_0080, 41'h000_1000_0080,
    41'h000_8000_0080, 41'h004_0000_0080, 41'h020_0000_0080, 41'h100_0000_0080};
  localparam logic [CNT_W-1:0] SETTLE_PERIODS [4] = '{
    41'h000_0000_0480, 41'h000_0200_0080, 41'h000_1000_0080, 41'h000_8000_0080};
  localparam logic [CNT_W-1:0] CNT_ONE = 41'h000_0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 41'h000_0000_0000;

  typedef enum logic [1:0] {
    LPCAL_IDLE   = 2'b00,
    LPCAL_SLEEP  = 2'b01,
    LPCAL_SETTLE = 2'b10,
    LPCAL_CAL    = 2'b11
  } lpcal_state_t;

  typedef struct packed {
    logic [7:0]       soft_trig;
    logic [7:0]       lp_ctrl;
    logic [7:0]       gain_trim;
  } lpcal_regs_t;

  typedef struct packed {
    lpcal_regs_t      regs;
    lpcal_state_t     state;
    logic [CNT_W-1:0] cnt;
    logic             trig;
    logic             sleep;
    logic             cal_start;
    logic [7:0]       rdata;
  } lpcal_all_t;
endpackage
`default_nettype wire

// *** verif/lpcal_host.sv ***
// Purpose: host and calibration engine model beside the sequencer
// Assumes: one-cycle strobes, signals move just after the edge
// Notes:   done answer alternates prompt and slow
`timescale 1ns/1ns
`default_nettype none
module lpcal_host
  import lpcal_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              cal_start_in,
  output logic                   wr_en_out,
  output logic                   rd_en_out,
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [7:0]        wdata_out,
  output logic                   cal_done_out
);
  int dly = 0;
  bit slow = 0;
  initial {wr_en_out, rd_en_out, addr_out, wdata_out, cal_done_out} = '0;
  ////////////////////////////////////////////////////////////
  // one access, strobe held for one sampling edge
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_en_out <= w;
    rd_en_out <= !w;
    addr_out  <= a;
    wdata_out <= d; // reserved bits kept at default by callers
    @(posedge clock_in);
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b0;
    addr_out  <= ~a; // released bus shows no stale value
    wdata_out <= ~d;
  endtask
  // calibration engine, done after 1 or 6 cycles
  always @(posedge clock_in) begin
    cal_done_out <= 1'b0;
    if (cal_start_in) begin
      dly  <= slow ? 6 : 1;
      slow <= !slow;
    end else if (dly > 1) dly <= dly - 1;
    else if (dly == 1) begin
      dly          <= 0;
      cal_done_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verif/lpcal_seq_tb.sv ***
// Purpose: self-checking bench for the calibration sequencer
// Assumes: shortened interval parameters
// Notes:   sleep and settle lengths measured at the outputs
`timescale 1ns/1ns
`default_nettype none
module lpcal_seq_tb;
  import lpcal_pkg::*;
  localparam logic [CNT_W-1:0] SLP [8] = '{41'h8, 41'h9, 41'hb, 41'hd, 41'h10, 41'h13, 41'h17, 41'h1c};
  localparam logic [CNT_W-1:0] STL [4] = '{41'h4, 41'h6, 41'h9, 41'h5};
  logic clock_in = 1'b0, rst_n_in = 1'b0, pin = 1'b0, sel = 1'b0, bg = 1'b1;
  logic wr, rd, done, start, trig, slp;
  logic [ADDR_W-1:0] addr;
  logic [7:0] fuse = 8'h00, wd, rdat, gain, g;
  logic [7:0] rq[$];
  logic [CNT_W-1:0] sq[$], tq[$];
  int err_total = 0, checks = 0, sc = 0, wc = 0;
  bit rd_pend = 0;
  always #10 clock_in = ~clock_in;
  lpcal_seq #(.SLEEP_CYCLES(SLP), .SETTLE_CYCLES(STL)) dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wd), .cal_trigger_pin_in(pin), .trigger_source_select_in(sel),
    .background_cal_enable_in(bg), .fuse_gain_trim_in(fuse), .cal_done_in(done),
    .reg_rdata_out(rdat), .cal_trigger_out(trig), .core_sleep_out(slp),
    .cal_start_out(start), .gain_trim_out(gain));
  lpcal_host host (.clock_in(clock_in), .cal_start_in(start), .wr_en_out(wr),
    .rd_en_out(rd), .addr_out(addr), .wdata_out(wd), .cal_done_out(done));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [CNT_W-1:0] e, input logic [CNT_W-1:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rdx(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    rq.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  // output watcher: read data, sleep length, settle length
  always @(posedge clock_in) begin
    rd_pend <= rd;
    if (rd_pend && rq.size() > 0) chk("rdata", {33'h0, rq.pop_front()}, {33'h0, rdat});
    if (slp) sc <= sc + 1;
    else if (sc != 0) begin
      sc <= 0;
      if (sq.size() > 0) begin
        chk("sleep", sq.pop_front(), CNT_W'(sc));
        wc <= 1;
      end
    end else if (wc != 0) begin
      if (start) begin
        if (tq.size() > 0) chk("settle", tq.pop_front(), CNT_W'(wc));
        wc <= 0;
      end else wc <= wc + 1;
    end
  end
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h149209cb));
    fuse = 8'($urandom());
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rdx(ADDR_SOFT_TRIG, 8'h01);
    rdx(ADDR_LP_CTRL, 8'h88);
    rdx(ADDR_GAIN_TRIM, fuse);
    rdx(15'h006d, 8'h00);
    g = 8'($urandom());
    host.acc(1'b1, ADDR_GAIN_TRIM, g);
    repeat (2) @(negedge clock_in);
    chk("gain", {33'h0, g}, {33'h0, gain});
    rdx(ADDR_GAIN_TRIM, g);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      sel <= i[2];
      pin <= i[0];
      host.acc(1'b1, ADDR_SOFT_TRIG, {7'h00, i[1]});
      repeat (2) @(negedge clock_in);
      chk("trigger", {40'h0, i[2] ? i[0] : i[1]}, {40'h0, trig});
    end
    sel <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      host.acc(1'b1, ADDR_LP_CTRL, 8'h00);
      host.acc(1'b1, ADDR_LP_CTRL, 8'({c[2:0], c[1:0], 3'b001}));
      @(negedge clock_in);
      repeat (2) begin
        sq.push_back(SLP[c]);
        tq.push_back(STL[c % 4]);
      end
      for (int k = 0; k < 400 && tq.size() > 0; k++) @(posedge clock_in);
      chk("pending", 41'h0, CNT_W'(tq.size()));
    end
    host.acc(1'b1, ADDR_LP_CTRL, 8'h00);
    host.acc(1'b1, ADDR_LP_CTRL, 8'h8b);
    repeat (40) @(negedge clock_in);
    chk("trig sleep", 41'h1, {40'h0, slp});
    host.acc(1'b1, ADDR_SOFT_TRIG, 8'h00);
    repeat (4) @(negedge clock_in);
    chk("trig wake", 41'h0, {40'h0, slp});
    host.acc(1'b1, ADDR_LP_CTRL, 8'h00);
    bg <= 1'b0;
    host.acc(1'b1, ADDR_LP_CTRL, 8'h89);
    repeat (30) @(negedge clock_in);
    chk("bg off", 41'h0, {40'h0, slp});
    rdx(ADDR_LP_CTRL, 8'h89);
    // mid-run reset with a fresh fuse value
    @(posedge clock_in);
    fuse     <= 8'($urandom());
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rdx(ADDR_GAIN_TRIM, fuse);
    rdx(ADDR_SOFT_TRIG, RST_SOFT_TRIG);
    rdx(ADDR_LP_CTRL, RST_LP_CTRL);
    repeat (3) @(posedge clock_in);
    stop_test();
  end
endmodule
`default_nettype wire
